//--- verilog/rx_loss_pkg.sv
// package: register map, field layout and carrier types for the rx loss bank
// Behaviour
// - counters share one word, top bits zero
// - fifo-full drop count bits 27:17, read clears
// - bit 28 fifo-full wrap, read clears
// - no-buffer drop count bits 15:0, read clears
// - bit 16 no-buffer wrap, read clears
// - tx buffer pointer read-only, reset zero
// - rx buffer pointer read-only, reset zero
// - mac control word at its offset
// - bit 31 receives every frame that bit 23 does not block
// - receive-all reports filter result in status
// - receive-all clear forwards only address matches
// - bit 23 blocks receive while transmitting
// - echo block clear accepts frames while transmitting
// - bit 20 selects full duplex
// - no descriptor suspends receive, sets flag
`default_nettype none
package rx_loss_pkg;
  localparam logic [7:0] OFF_DROP_CNT  = 8'h20;
  localparam logic [7:0] OFF_TX_PTR    = 8'h50;
  localparam logic [7:0] OFF_RX_PTR    = 8'h54;
  localparam logic [7:0] OFF_MAC_CTRL  = 8'h80;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'hc0;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'hc4;

  localparam int FIFO_WRAP_BIT   = 28;
  localparam int FIFO_CNT_LSB    = 17;
  localparam int FIFO_CNT_W      = 11;
  localparam int NOBUF_WRAP_BIT  = 16;
  localparam int NOBUF_CNT_W     = 16;
  localparam int RECEIVE_EVERYTHING_BIT       = 31;
  localparam int ECHO_BIT        = 23;
  localparam int FULL_DUPLEX_SELECT_BIT        = 20;

  localparam logic [31:0] MAC_CTRL_WMASK = 32'h80900000;
  localparam logic [31:0] MAC_CTRL_RESET = 32'h00000000;
  localparam logic [31:0] PTR_RESET      = 32'h00000000;

  localparam int IRQ_W = 4;
  // irq status bits: fifo wrap, nobuf wrap, fifo drop, no-buffer suspend
  localparam int IRQ_FIFO_WRAP  = 0;
  localparam int IRQ_NOBUF_WRAP = 1;
  localparam int IRQ_FIFO_DROP  = 2;
  localparam int IRQ_NOBUF_SUSP = 3;

  typedef struct packed {
    logic        frameValid;
    logic        addrMatch;
    logic        txActive;
  } rx_frame_t;

  typedef struct packed {
    logic        accept;
    logic        filterFail;
  } rx_verdict_t;
endpackage
`default_nettype wire

//--- verilog/rx_loss_counters_and_mac_control.sv
// register bank: dropped frame counters, dma buffer pointers, mac control
`timescale 1ns/1ns
`default_nettype none
module rx_loss_counters_and_mac_control (
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  output logic                        wb_err_o,
  input  wire logic                   fifoFullDrop,
  input  wire logic                   noBufferDrop,
  input  wire logic                   noOwnedDescriptor,
  input  wire logic [31:0]            txBufPtr,
  input  wire logic                   txBufPtrLoad,
  input  wire logic [31:0]            rxBufPtr,
  input  wire logic                   rxBufPtrLoad,
  input  wire rx_loss_pkg::rx_frame_t rxFrame,
  output rx_loss_pkg::rx_verdict_t    rxVerdict,
  output logic                        fullDuplexSelect,
  output logic                        rxSuspended,
  output logic                        rxBufferUnavailableFlag,
  output logic                        irq
);
  logic [10:0] fifoCnt_ff;
  logic        fifoWrap_ff;
  logic [15:0] nobufCnt_ff;
  logic        nobufWrap_ff;
  logic [31:0] txPtr_ff;
  logic [31:0] rxPtr_ff;
  logic [31:0] macCtrl_ff;
  logic [3:0]  irqStat_ff;
  logic [3:0]  irqMask_ff;
  logic        ack_ff;
  logic        err_ff;
  logic [31:0] rdData_ff;
  logic        suspend_ff;
  logic        ruFlag_ff;
  logic [31:0] nxt_rdData;
  logic        mapped;
  logic        take;
  logic        rdCnt;
  logic        rdStat;
  logic        wrCtrl;
  logic        wrMask;
  logic [3:0]  irqEvent;

  // byte-lane merge used by the mac control register; the irq mask takes lane 0 directly
  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] din,
                                            input logic [3:0] sel, input logic [31:0] wmask);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & wmask;
    laneMerge = (old & ~m) | (din & m);
  endfunction

  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == rx_loss_pkg::OFF_DROP_CNT) || (a == rx_loss_pkg::OFF_TX_PTR) ||
               (a == rx_loss_pkg::OFF_RX_PTR) || (a == rx_loss_pkg::OFF_MAC_CTRL) ||
               (a == rx_loss_pkg::OFF_IRQ_STAT) || (a == rx_loss_pkg::OFF_IRQ_MASK);
  endfunction

  // one request per bus cycle; ack drops the cycle after it is given
  assign take   = wb_cyc_i && wb_stb_i && !ack_ff && !err_ff;
  assign mapped = isMapped(wb_adr_i);
  assign rdCnt  = take && mapped && !wb_we_i && wb_adr_i == rx_loss_pkg::OFF_DROP_CNT;
  assign rdStat = take && mapped && !wb_we_i && wb_adr_i == rx_loss_pkg::OFF_IRQ_STAT;
  assign wrCtrl = take && wb_we_i && wb_adr_i == rx_loss_pkg::OFF_MAC_CTRL;
  assign wrMask = take && wb_we_i && wb_adr_i == rx_loss_pkg::OFF_IRQ_MASK;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      ack_ff <= take && mapped;
      err_ff <= take && !mapped;
    end
  end

  always_comb begin
    nxt_rdData = 32'h00000000;
    case (wb_adr_i)
      rx_loss_pkg::OFF_DROP_CNT: nxt_rdData = {3'h0, fifoWrap_ff, fifoCnt_ff, nobufWrap_ff, nobufCnt_ff};
      rx_loss_pkg::OFF_TX_PTR:   nxt_rdData = txPtr_ff;
      rx_loss_pkg::OFF_RX_PTR:   nxt_rdData = rxPtr_ff;
      rx_loss_pkg::OFF_MAC_CTRL: nxt_rdData = macCtrl_ff;
      rx_loss_pkg::OFF_IRQ_STAT: nxt_rdData = {28'h0000000, irqStat_ff};
      rx_loss_pkg::OFF_IRQ_MASK: nxt_rdData = {28'h0000000, irqMask_ff};
      default:                   nxt_rdData = 32'h00000000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdData_ff <= 32'h00000000;
    end else if (take && !wb_we_i) begin
      rdData_ff <= nxt_rdData;
    end
  end

  assign wb_dat_o = rdData_ff;
  assign wb_ack_o = ack_ff;
  assign wb_err_o = err_ff;

  // read clears, but an increment in the same cycle counts from zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fifoCnt_ff  <= 11'h000;
      fifoWrap_ff <= 1'b0;
    end else begin
      if (rdCnt) begin
        fifoCnt_ff  <= {10'h000, fifoFullDrop};
        fifoWrap_ff <= 1'b0;
      end else if (fifoFullDrop) begin
        fifoCnt_ff <= fifoCnt_ff + 11'h001;
        if (&fifoCnt_ff) begin
          fifoWrap_ff <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      nobufCnt_ff  <= 16'h0000;
      nobufWrap_ff <= 1'b0;
    end else begin
      if (rdCnt) begin
        nobufCnt_ff  <= {15'h0000, noBufferDrop};
        nobufWrap_ff <= 1'b0;
      end else if (noBufferDrop) begin
        nobufCnt_ff <= nobufCnt_ff + 16'h0001;
        if (&nobufCnt_ff) begin
          nobufWrap_ff <= 1'b1;
        end
      end
    end
  end

  // pointers follow the dma engine only; bus writes never reach them
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      txPtr_ff <= rx_loss_pkg::PTR_RESET;
      rxPtr_ff <= rx_loss_pkg::PTR_RESET;
    end else begin
      if (txBufPtrLoad) begin
        txPtr_ff <= txBufPtr;
      end
      if (rxBufPtrLoad) begin
        rxPtr_ff <= rxBufPtr;
      end
    end
  end

  // only the three modelled control bits are writable, the rest read zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      macCtrl_ff <= rx_loss_pkg::MAC_CTRL_RESET;
    end else if (wrCtrl) begin
      macCtrl_ff <= laneMerge(macCtrl_ff, wb_dat_i, wb_sel_i, rx_loss_pkg::MAC_CTRL_WMASK);
    end
  end

  assign fullDuplexSelect = macCtrl_ff[rx_loss_pkg::FULL_DUPLEX_SELECT_BIT];

  // frame verdict; echo block is honoured even in full duplex, software keeps it off there
  always_comb begin
    rxVerdict = '0;
    if (rxFrame.frameValid && !(macCtrl_ff[rx_loss_pkg::ECHO_BIT] && rxFrame.txActive)) begin
      if (macCtrl_ff[rx_loss_pkg::RECEIVE_EVERYTHING_BIT]) begin
        rxVerdict.accept     = 1'b1;
        rxVerdict.filterFail = !rxFrame.addrMatch;
      end else begin
        rxVerdict.accept = rxFrame.addrMatch;
      end
    end
  end

  // suspend held until the dma engine finds a descriptor again
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      suspend_ff <= 1'b0;
      ruFlag_ff  <= 1'b0;
    end else begin
      suspend_ff <= noOwnedDescriptor;
      if (noOwnedDescriptor) begin
        ruFlag_ff <= 1'b1;
      end else if (rdStat) begin
        ruFlag_ff <= 1'b0;
      end
    end
  end

  assign rxSuspended             = suspend_ff;
  assign rxBufferUnavailableFlag = ruFlag_ff;

  assign irqEvent = {noOwnedDescriptor && !suspend_ff, fifoFullDrop,
                     noBufferDrop && (&nobufCnt_ff) && !rdCnt, fifoFullDrop && (&fifoCnt_ff) && !rdCnt};

  // set wins over the clear by read
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irqStat_ff <= 4'h0;
      irqMask_ff <= 4'h0;
    end else begin
      irqStat_ff <= (rdStat ? 4'h0 : irqStat_ff) | irqEvent;
      if (wrMask && wb_sel_i[0]) begin
        irqMask_ff <= wb_dat_i[3:0];
      end
    end
  end

  assign irq = |(irqStat_ff & irqMask_ff);

  sequence cntRead;
    rdCnt && !fifoFullDrop && !noBufferDrop;
  endsequence

  chk_read_clears_counters: assert property (@(posedge core_clk) disable iff (!rst_n)
    cntRead |=> fifoCnt_ff == 11'h000 && nobufCnt_ff == 16'h0000)
    else $error("counters not cleared by read");
  chk_read_clears_wraps: assert property (@(posedge core_clk) disable iff (!rst_n)
    rdCnt |=> !fifoWrap_ff && !nobufWrap_ff)
    else $error("wrap flags not cleared by read");
  chk_nobuf_increment: assert property (@(posedge core_clk) disable iff (!rst_n)
    noBufferDrop && !rdCnt |=> nobufCnt_ff == $past(nobufCnt_ff) + 16'h0001)
    else $error("no-buffer count did not step");
  chk_nobuf_wrap_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    noBufferDrop && !rdCnt && nobufCnt_ff == 16'hffff |=> nobufWrap_ff && nobufCnt_ff == 16'h0000)
    else $error("no-buffer wrap not flagged");
  chk_fifo_wrap_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    fifoFullDrop && !rdCnt && fifoCnt_ff == 11'h7ff |=> fifoWrap_ff && fifoCnt_ff == 11'h000)
    else $error("fifo wrap not flagged");
  chk_read_race_kept: assert property (@(posedge core_clk) disable iff (!rst_n)
    rdCnt && fifoFullDrop |=> fifoCnt_ff == 11'h001)
    else $error("increment lost at read");
  chk_upper_bits_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    rdCnt |=> wb_ack_o && wb_dat_o[31:29] == 3'h0)
    else $error("reserved bits not zero");
  chk_tx_ptr_readonly: assert property (@(posedge core_clk) disable iff (!rst_n)
    !txBufPtrLoad |=> txPtr_ff == $past(txPtr_ff))
    else $error("tx pointer changed without load");
  chk_rx_ptr_readonly: assert property (@(posedge core_clk) disable iff (!rst_n)
    !rxBufPtrLoad |=> rxPtr_ff == $past(rxPtr_ff))
    else $error("rx pointer changed without load");
  chk_ctrl_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    wrCtrl && wb_sel_i == 4'hf |=> macCtrl_ff == ($past(wb_dat_i) & rx_loss_pkg::MAC_CTRL_WMASK))
    else $error("control write lost");
  chk_receive_all: assert property (@(posedge core_clk) disable iff (!rst_n)
    macCtrl_ff[31] && !macCtrl_ff[23] && rxFrame.frameValid |-> rxVerdict.accept)
    else $error("receive-all dropped a frame");
  chk_filter_status: assert property (@(posedge core_clk) disable iff (!rst_n)
    rxVerdict.accept && macCtrl_ff[31] |-> rxVerdict.filterFail == !rxFrame.addrMatch)
    else $error("filter result not reported");
  chk_filter_only: assert property (@(posedge core_clk) disable iff (!rst_n)
    !macCtrl_ff[31] |-> rxVerdict.accept == (rxFrame.frameValid && rxFrame.addrMatch
                                              && !(macCtrl_ff[23] && rxFrame.txActive)))
    else $error("filter gating wrong");
  chk_echo_block: assert property (@(posedge core_clk) disable iff (!rst_n)
    macCtrl_ff[23] && rxFrame.txActive |-> !rxVerdict.accept)
    else $error("own frame received");
  chk_echo_pass: assert property (@(posedge core_clk) disable iff (!rst_n)
    !macCtrl_ff[23] && macCtrl_ff[31] && rxFrame.frameValid && rxFrame.txActive |-> rxVerdict.accept)
    else $error("echo frame wrongly blocked");
  chk_duplex_out: assert property (@(posedge core_clk) disable iff (!rst_n)
    wrCtrl && wb_sel_i[2] |=> fullDuplexSelect == $past(wb_dat_i[20]))
    else $error("duplex select not taken");
  chk_no_descriptor: assert property (@(posedge core_clk) disable iff (!rst_n)
    noOwnedDescriptor |=> rxSuspended && rxBufferUnavailableFlag)
    else $error("receive not suspended");

  // bus answers: one pulse of ack or err per taken request, never both
  sequence ackPulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  sequence errPulse;
    wb_err_o ##1 !wb_err_o;
  endsequence

  chk_ack_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
    take && mapped |=> ackPulse)
    else $error("ack not a single pulse");
  chk_err_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
    take && !mapped |=> errPulse)
    else $error("err not a single pulse");
  chk_ack_err_apart: assert property (@(posedge core_clk) disable iff (!rst_n)
    !(wb_ack_o && wb_err_o))
    else $error("ack and err together");
  chk_err_data_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    take && !mapped && !wb_we_i |=> wb_dat_o == 32'h00000000)
    else $error("unmapped read returned data");
  chk_write_keeps_data: assert property (@(posedge core_clk) disable iff (!rst_n)
    take && wb_we_i |=> wb_dat_o == $past(wb_dat_o))
    else $error("write disturbed read data");

  // counters step by one per drop unless a read restarts them
  chk_fifo_increment: assert property (@(posedge core_clk) disable iff (!rst_n)
    fifoFullDrop && !rdCnt |=> fifoCnt_ff == $past(fifoCnt_ff) + 11'h001)
    else $error("fifo-full count did not step");
  chk_fifo_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
    !fifoFullDrop && !rdCnt |=> fifoCnt_ff == $past(fifoCnt_ff))
    else $error("fifo-full count moved without a drop");
  chk_nobuf_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
    !noBufferDrop && !rdCnt |=> nobufCnt_ff == $past(nobufCnt_ff))
    else $error("no-buffer count moved without a drop");
  chk_nobuf_race_kept: assert property (@(posedge core_clk) disable iff (!rst_n)
    rdCnt && noBufferDrop |=> nobufCnt_ff == 16'h0001)
    else $error("no-buffer increment lost at read");
  chk_count_fields: assert property (@(posedge core_clk) disable iff (!rst_n)
    rdCnt |=> wb_dat_o[27:17] == $past(fifoCnt_ff) && wb_dat_o[15:0] == $past(nobufCnt_ff))
    else $error("count fields misplaced");
  chk_count_wraps: assert property (@(posedge core_clk) disable iff (!rst_n)
    rdCnt |=> wb_dat_o[28] == $past(fifoWrap_ff) && wb_dat_o[16] == $past(nobufWrap_ff))
    else $error("wrap bits misplaced");
  chk_fifo_wrap_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    fifoWrap_ff && !rdCnt |=> fifoWrap_ff)
    else $error("fifo wrap flag lost");
  chk_nobuf_wrap_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    nobufWrap_ff && !rdCnt |=> nobufWrap_ff)
    else $error("no-buffer wrap flag lost");

  // pointers load from the dma engine and answer reads with the held value
  chk_tx_ptr_load: assert property (@(posedge core_clk) disable iff (!rst_n)
    txBufPtrLoad |=> txPtr_ff == $past(txBufPtr))
    else $error("tx pointer load missed");
  chk_rx_ptr_load: assert property (@(posedge core_clk) disable iff (!rst_n)
    rxBufPtrLoad |=> rxPtr_ff == $past(rxBufPtr))
    else $error("rx pointer load missed");
  chk_tx_ptr_data: assert property (@(posedge core_clk) disable iff (!rst_n)
    take && !wb_we_i && wb_adr_i == rx_loss_pkg::OFF_TX_PTR |=> wb_dat_o == $past(txPtr_ff))
    else $error("tx pointer read wrong");
  chk_rx_ptr_data: assert property (@(posedge core_clk) disable iff (!rst_n)
    take && !wb_we_i && wb_adr_i == rx_loss_pkg::OFF_RX_PTR |=> wb_dat_o == $past(rxPtr_ff))
    else $error("rx pointer read wrong");

  // unmodelled control bits must never hold a one, whatever software writes
  chk_ctrl_data: assert property (@(posedge core_clk) disable iff (!rst_n)
    take && !wb_we_i && wb_adr_i == rx_loss_pkg::OFF_MAC_CTRL |=> wb_dat_o == $past(macCtrl_ff))
    else $error("control read wrong");
  chk_ctrl_reserved: assert property (@(posedge core_clk) disable iff (!rst_n)
    (macCtrl_ff & ~rx_loss_pkg::MAC_CTRL_WMASK) == 32'h00000000)
    else $error("reserved control bit set");
  chk_ctrl_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    !wrCtrl |=> macCtrl_ff == $past(macCtrl_ff))
    else $error("control changed without write");
  chk_ctrl_lanes: assert property (@(posedge core_clk) disable iff (!rst_n)
    wrCtrl && !wb_sel_i[3] |=> macCtrl_ff[31] == $past(macCtrl_ff[31]))
    else $error("disabled lane written");
  chk_verdict_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
    !rxFrame.frameValid |-> !rxVerdict.accept && !rxVerdict.filterFail)
    else $error("verdict without a frame");

  // suspend, unavailable flag and status; a set beats a clearing read
  chk_suspend_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
    !noOwnedDescriptor |=> !rxSuspended)
    else $error("suspend held without cause");
  chk_suspend_event: assert property (@(posedge core_clk) disable iff (!rst_n)
    noOwnedDescriptor && !rxSuspended |=> irqStat_ff[rx_loss_pkg::IRQ_NOBUF_SUSP])
    else $error("suspend event not recorded");
  chk_ru_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
    rxBufferUnavailableFlag && !rdStat |=> rxBufferUnavailableFlag)
    else $error("unavailable flag lost");
  chk_ru_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    rdStat && !noOwnedDescriptor |=> !rxBufferUnavailableFlag)
    else $error("unavailable flag not cleared");
  chk_irq_set_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
    (|irqEvent) |=> (irqStat_ff & $past(irqEvent)) == $past(irqEvent))
    else $error("status event lost");
  chk_irq_read_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    rdStat && irqEvent == 4'h0 |=> irqStat_ff == 4'h0)
    else $error("status not cleared by read");
  chk_stat_data: assert property (@(posedge core_clk) disable iff (!rst_n)
    rdStat |=> wb_dat_o == {28'h0000000, $past(irqStat_ff)})
    else $error("status read wrong");
  chk_mask_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    wrMask && wb_sel_i[0] |=> irqMask_ff == $past(wb_dat_i[3:0]))
    else $error("mask write lost");
endmodule
`default_nettype wire

//--- tb/rx_loss_counters_and_mac_control_bench.sv
// bench: register bank of the rx loss counters, buffer pointers and mac control
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checkCount++; if ((g) !== (e)) begin nMismatch++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module rx_loss_counters_and_mac_control_bench;
  logic                      clk = 1'b0;
  logic                      rstN = 1'b0;
  logic                      cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]                adr = 8'h00;
  logic [3:0]                sel = 4'hf, lanes = 4'hf;
  logic [31:0]               datI = 32'h0, datO, txBufPtr = 32'h0, rxBufPtr = 32'h0, p, q, d;
  logic                      ack, err, fifoFullDrop = 1'b0, noBufferDrop = 1'b0, noOwnedDescriptor = 1'b0;
  logic                      txBufPtrLoad = 1'b0, rxBufPtrLoad = 1'b0, fullDuplexSelect, rxSuspended;
  logic                      rxBufferUnavailableFlag, irq, acc;
  rx_loss_pkg::rx_frame_t    rxFrame = '0;
  rx_loss_pkg::rx_verdict_t  rxVerdict;
  logic [33:0]               expQ[$];
  logic [33:0]               e;
  logic [31:0]               seed = 32'h0000004c;
  int                        nMismatch = 0, checkCount = 0;

  always #5 clk = ~clk;

  rx_loss_counters_and_mac_control i_rx_loss_counters_and_mac_control (
    .core_clk(clk), .rst_n(rstN), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack), .wb_err_o(err),
    .fifoFullDrop(fifoFullDrop), .noBufferDrop(noBufferDrop), .noOwnedDescriptor(noOwnedDescriptor),
    .txBufPtr(txBufPtr), .txBufPtrLoad(txBufPtrLoad), .rxBufPtr(rxBufPtr), .rxBufPtrLoad(rxBufPtrLoad),
    .rxFrame(rxFrame), .rxVerdict(rxVerdict), .fullDuplexSelect(fullDuplexSelect),
    .rxSuspended(rxSuspended), .rxBufferUnavailableFlag(rxBufferUnavailableFlag), .irq(irq));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checkCount, nMismatch);
    if (nMismatch == 0 && checkCount > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // expectation word: err, data valid, data
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dv, input logic [33:0] ex);
    int n;
    expQ.push_back(ex);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datI <= dv;
    sel <= lanes;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!(ack === 1'b1 || err === 1'b1) && n < 20);
    if (n >= 20) begin
      nMismatch++;
      print_verdict();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] v);
    bus(1'b0, a, 32'h0, {2'b01, v});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bus(1'b1, a, v, 34'h0);
  endtask

  // answers are matched in order against the notes left by the driver
  always @(posedge clk) begin
    if (ack === 1'b1 || err === 1'b1) begin
      if (expQ.size() == 0) begin
        nMismatch++;
        $display("mismatch answer expected none seen one");
      end else begin
        e = expQ.pop_front();
        `CHK("err", e[33], err)
        if (e[32]) `CHK("rdata", e[31:0], datO)
      end
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    rstN <= 1'b1;
    rd(8'h50, 32'h0);
    rd(8'h54, 32'h0);
    rd(8'h80, 32'h0);
    rd(8'h20, 32'h0);
    rd(8'hc0, 32'h0);
    p = rnd();
    q = rnd();
    @(posedge clk);
    txBufPtr <= p;
    rxBufPtr <= q;
    txBufPtrLoad <= 1'b1;
    rxBufPtrLoad <= 1'b1;
    @(posedge clk);
    txBufPtrLoad <= 1'b0;
    rxBufPtrLoad <= 1'b0;
    txBufPtr <= rnd();
    wr(8'h50, ~p);
    wr(8'h54, ~q);
    rd(8'h50, p);
    rd(8'h54, q);
    bus(1'b0, 8'h24, 32'h0, {2'b11, 32'h0});
    $display("test pointers and map done");

    @(posedge clk);
    fifoFullDrop <= 1'b1;
    noBufferDrop <= 1'b1;
    repeat (3) @(posedge clk);
    fifoFullDrop <= 1'b0;
    repeat (2) @(posedge clk);
    noBufferDrop <= 1'b0;
    rd(8'h20, 32'h00060005);
    rd(8'h20, 32'h0);
    // 65537 and 2049 drops: both counters pass all-ones and land on one
    @(posedge clk);
    fifoFullDrop <= 1'b1;
    noBufferDrop <= 1'b1;
    for (int i = 0; i < 65537; i++) begin
      @(posedge clk);
      if (i == 2048) fifoFullDrop <= 1'b0;
    end
    noBufferDrop <= 1'b0;
    rd(8'h20, 32'h10030001);
    rd(8'h20, 32'h0);
    // drops keep coming while the counters are read: none may be lost
    @(posedge clk);
    fifoFullDrop <= 1'b1;
    noBufferDrop <= 1'b1;
    rd(8'h20, 32'h00020001);
    fifoFullDrop <= 1'b0;
    noBufferDrop <= 1'b0;
    rd(8'h20, 32'h00040002);
    $display("test counters done");

    @(posedge clk);
    #1 `CHK("irq masked", 1'b0, irq)
    wr(8'hc4, 32'h1);
    @(posedge clk);
    #1 `CHK("irq wrap", 1'b1, irq)
    rd(8'hc0, 32'h7);
    @(posedge clk);
    #1 `CHK("irq cleared", 1'b0, irq)
    wr(8'hc4, 32'h8);
    noOwnedDescriptor <= 1'b1;
    repeat (2) @(posedge clk);
    #1 `CHK("suspended", 1'b1, rxSuspended)
    `CHK("unavail", 1'b1, rxBufferUnavailableFlag)
    `CHK("irq suspend", 1'b1, irq)
    noOwnedDescriptor <= 1'b0;
    rd(8'hc0, 32'h8);
    @(posedge clk);
    #1 `CHK("unavail clr", 1'b0, rxBufferUnavailableFlag)
    `CHK("irq off", 1'b0, irq)
    $display("test interrupts done");

    for (int c = 0; c < 4; c++) begin
      d = rnd();
      d[31] = c[1];
      d[23] = c[0];
      if (c[0]) d[20] = 1'b0;
      wr(8'h80, d);
      rd(8'h80, d & 32'h80900000);
      `CHK("duplex", d[20], fullDuplexSelect)
      for (int f = 0; f < 8; f++) begin
        rxFrame <= rx_loss_pkg::rx_frame_t'(f[2:0]);
        @(posedge clk);
        #1 acc = f[2] & (c[1] | f[1]) & ~(c[0] & f[0]);
        `CHK("accept", acc, rxVerdict.accept)
        `CHK("filterfail", acc & ~f[1], rxVerdict.filterFail)
      end
    end
    lanes = 4'h4;
    wr(8'h80, 32'h0);
    lanes = 4'hf;
    rd(8'h80, 32'h80000000);
    `CHK("duplex lane", 1'b0, fullDuplexSelect)
    $display("test control and verdict done");
    print_verdict();
  end
endmodule
`default_nettype wire
